// ===== verilog/rivm_ctrl.sv
////////////////////////////////////////////////////////////////////////////////
// Behaviour
// - Unprogrammed fuse: reset fetches address zero.
// - Stage controller events vector to 0x0002-0x000c.
// - Comparators vector to 0x000e, 0x0010, 0x0012.
// - External requests vector 0x0014/0x0026/0x0030/0x0038.
// - Wide timer vectors; slot 0x001c unused.
// - Byte timer vectors 0x0020, 0x0022, 0x0036.
// - Converter 0x0024, SPI transfer 0x0028.
// - Serial unit vectors 0x002a, 0x002c, 0x002e.
// - Watchdog, EEPROM, self-program; 0x003a/0x003c unused.
// - Programmed fuse: reset fetches boot address.
// - Select bit adds boot start to vectors.
// - Reset and table base chosen independently.
module rivm_ctrl
  import rivm_pkg::*;
(
  input  wire logic                       core_clk,
  input  wire logic                       arst_n,
  input  wire logic                       boot_reset_fuse,
  input  wire logic                       vector_table_select,
  input  wire logic [PC_W-1:0]            boot_addr,
  input  wire logic                       global_enable,
  input  wire logic                       stage_ctrl2_capture_irq,
  input  wire logic                       stage_ctrl2_cycle_end_irq,
  input  wire logic                       stage_ctrl1_capture_irq,
  input  wire logic                       stage_ctrl1_cycle_end_irq,
  input  wire logic                       stage_ctrl0_capture_irq,
  input  wire logic                       stage_ctrl0_cycle_end_irq,
  input  wire logic                       comparator_zero_irq,
  input  wire logic                       comparator_one_irq,
  input  wire logic                       comparator_two_irq,
  input  wire logic                       ext_request_zero,
  input  wire logic                       ext_request_one,
  input  wire logic                       ext_request_two,
  input  wire logic                       ext_request_three,
  input  wire logic                       wide_timer_capture_irq,
  input  wire logic                       wide_timer_match_a_irq,
  input  wire logic                       wide_timer_match_b_irq,
  input  wire logic                       wide_timer_overflow_irq,
  input  wire logic                       byte_timer_match_a_irq,
  input  wire logic                       byte_timer_overflow_irq,
  input  wire logic                       byte_timer_match_b_irq,
  input  wire logic                       converter_done_irq,
  input  wire logic                       spi_done_irq,
  input  wire logic                       serial_rx_done_irq,
  input  wire logic                       serial_tx_empty_irq,
  input  wire logic                       serial_tx_done_irq,
  input  wire logic                       watchdog_timeout_irq,
  input  wire logic                       eeprom_ready_irq,
  input  wire logic                       self_program_ready_irq,
  input  wire logic                       core_ack,
  output logic                            pc_load_q,
  output logic      [PC_W-1:0]            pc_addr_q,
  output logic                            irq_ack_q,
  output logic      [4:0]                 irq_slot_q
);

  ////////////////////////////////////////////////////////////////////////////////
  // Request gathering.

  logic [NUM_VEC-1:0] req_w;
  logic [NUM_VEC-1:0] req_m_w;
  logic [NUM_VEC-1:0] pin_s1_q;
  logic [NUM_VEC-1:0] pin_s2_q;
  logic [NUM_VEC-1:0] pin_raw_w;
  logic               fuse_q;
  logic               sel_q;
  logic [PC_W-1:0]    boot_q;
  logic [PC_W-1:0]    rom_ofs_w;
  logic               any_w;
  logic [4:0]         win_w;
  logic [4:0]         pend_slot_q;
  logic [4:0]         rom_slot_w;
  rivm_state_t        state_q;
  logic [1:0]         wait_q;

  // Each source sits at its slot; spare slots are tied low.
  always_comb begin
    pin_raw_w = '0;
    pin_raw_w[VEC_STG2_CAPT] = stage_ctrl2_capture_irq;
    pin_raw_w[VEC_STG2_END]  = stage_ctrl2_cycle_end_irq;
    pin_raw_w[VEC_STG1_CAPT] = stage_ctrl1_capture_irq;
    pin_raw_w[VEC_STG1_END]  = stage_ctrl1_cycle_end_irq;
    pin_raw_w[VEC_STG0_CAPT] = stage_ctrl0_capture_irq;
    pin_raw_w[VEC_STG0_END]  = stage_ctrl0_cycle_end_irq;
    pin_raw_w[VEC_CMP0] = comparator_zero_irq;
    pin_raw_w[VEC_CMP1] = comparator_one_irq;
    pin_raw_w[VEC_CMP2] = comparator_two_irq;
    pin_raw_w[VEC_EXT0] = ext_request_zero;
    pin_raw_w[VEC_EXT1] = ext_request_one;
    pin_raw_w[VEC_EXT2] = ext_request_two;
    pin_raw_w[VEC_EXT3] = ext_request_three;
    pin_raw_w[VEC_WT_CAPT] = wide_timer_capture_irq;
    pin_raw_w[VEC_WT_MA]   = wide_timer_match_a_irq;
    pin_raw_w[VEC_WT_MB]   = wide_timer_match_b_irq;
    pin_raw_w[VEC_WT_OVF]  = wide_timer_overflow_irq;
    pin_raw_w[VEC_BT_MA]  = byte_timer_match_a_irq;
    pin_raw_w[VEC_BT_OVF] = byte_timer_overflow_irq;
    pin_raw_w[VEC_BT_MB]  = byte_timer_match_b_irq;
    pin_raw_w[VEC_ADC] = converter_done_irq;
    pin_raw_w[VEC_SPI] = spi_done_irq;
    pin_raw_w[VEC_SER_RX]    = serial_rx_done_irq;
    pin_raw_w[VEC_SER_EMPTY] = serial_tx_empty_irq;
    pin_raw_w[VEC_SER_TX]    = serial_tx_done_irq;
    pin_raw_w[VEC_WDOG] = watchdog_timeout_irq;
    pin_raw_w[VEC_EE]  = eeprom_ready_irq;
    pin_raw_w[VEC_SPM] = self_program_ready_irq;
  end

  // External request pins cross from outside; every line gets two flops alike.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      pin_s1_q <= '0;
      pin_s2_q <= '0;
    end else begin
      pin_s1_q <= pin_raw_w;
      pin_s2_q <= pin_s1_q;
    end
  end

  assign req_w   = pin_s2_q & ~SPARE_MASK;
  assign req_m_w = global_enable ? req_w : '0;

  always_comb begin
    any_w = 1'b0;
    win_w = '0;
    for (int i = NUM_VEC - 1; i >= 0; i--) begin
      if (req_m_w[i]) begin
        any_w = 1'b1;
        win_w = 5'(i);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Straps and the table memory.

  // Fuse, select and boot address settle before use; captured each clock.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      fuse_q <= FUSE_UNPROGRAMMED;
      sel_q  <= 1'b0;
      boot_q <= BOOT_ADDR_DEFAULT;
    end else begin
      fuse_q <= boot_reset_fuse;
      sel_q  <= vector_table_select;
      boot_q <= boot_addr;
    end
  end

  // The table reads the held slot while waiting, so a newer request cannot swap the offset.
  assign rom_slot_w = (state_q == RIVM_WAIT_ACK) ? pend_slot_q : win_w;

  rivm_vec_rom u_rom (
    .core_clk (core_clk),
    .arst_n   (arst_n),
    .slot     (rom_slot_w),
    .offset_q (rom_ofs_w)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Sequencer: one reset fetch, then arbitration and acceptance.

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q     <= RIVM_RESET;
      wait_q      <= '0;
      pend_slot_q <= '0;
      pc_load_q   <= 1'b0;
      pc_addr_q   <= RESET_ADDR_APP;
      irq_ack_q   <= 1'b0;
      irq_slot_q  <= '0;
    end else begin
      pc_load_q <= 1'b0;
      irq_ack_q <= 1'b0;
      case (state_q)
        RIVM_RESET: begin
          // The strap flops hold reset values on the first edge; fetch on the second.
          if (wait_q == 2'h0) begin
            wait_q <= 2'h1;
          end else begin
            // reset address follows the fuse alone.
            pc_load_q <= 1'b1;
            // programmed fuse starts at boot address.
            pc_addr_q <= (fuse_q == FUSE_UNPROGRAMMED) ? RESET_ADDR_APP : boot_q;
            wait_q    <= 2'h0;
            state_q   <= RIVM_IDLE;
          end
        end
        RIVM_IDLE: begin
          // Hold-off after an ack lets the dropped request drain the synchroniser.
          if (wait_q != 2'h0) begin
            wait_q <= wait_q - 2'h1;
          end else if (any_w) begin
            pend_slot_q <= win_w;
            wait_q      <= 2'd1;
            state_q     <= RIVM_WAIT_ACK;
          end
        end
        default: begin
          // Table read lands one cycle after the slot was registered.
          if (wait_q != 2'd0) begin
            wait_q <= wait_q - 2'd1;
          end else if (core_ack) begin
            pc_load_q  <= 1'b1;
            pc_addr_q  <= (sel_q ? boot_q : RESET_ADDR_APP) + rom_ofs_w;
            irq_ack_q  <= 1'b1;
            irq_slot_q <= pend_slot_q;
            wait_q     <= 2'h3;
            state_q    <= RIVM_IDLE;
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks.

  property p_reset_fetch;
    @(posedge core_clk) disable iff (!arst_n)
      (state_q == RIVM_RESET && wait_q != 2'h0) |=> pc_load_q &&
        pc_addr_q == ($past(fuse_q) ? 13'h0000 : $past(boot_q));
  endproperty
  a_reset_fetch: assert property (p_reset_fetch) else $error("bad reset fetch");

  property p_vec_addr;
    @(posedge core_clk) disable iff (!arst_n)
      irq_ack_q |-> pc_load_q && pc_addr_q ==
        13'((sel_q ? boot_q : 13'h0000) + 13'({irq_slot_q, 1'b0}) + 13'h0002);
  endproperty
  a_vec_addr: assert property (p_vec_addr) else $error("vector address wrong");

  property p_lowest;
    @(posedge core_clk) disable iff (!arst_n)
      (state_q == RIVM_IDLE && wait_q == 2'h0 && any_w) |=> pend_slot_q == $past(win_w) &&
        ($past(req_m_w) & ((31'h1 << pend_slot_q) - 31'h1)) == '0;
  endproperty
  a_lowest: assert property (p_lowest) else $error("not lowest request");

  property p_spare;
    @(posedge core_clk) disable iff (!arst_n)
      irq_ack_q |-> !(irq_slot_q inside {5'd13, 5'd28, 5'd29});
  endproperty
  a_spare: assert property (p_spare) else $error("spare slot taken");

  property p_ext0;
    @(posedge core_clk) disable iff (!arst_n)
      (irq_ack_q && irq_slot_q == 5'd9 && !sel_q) |-> pc_addr_q == 13'h0014;
  endproperty
  a_ext0: assert property (p_ext0) else $error("ext zero address wrong");

  property p_spm;
    @(posedge core_clk) disable iff (!arst_n)
      (irq_ack_q && irq_slot_q == 5'd30 && !sel_q) |-> pc_addr_q == 13'h003e;
  endproperty
  a_spm: assert property (p_spm) else $error("self program address wrong");

  property p_ack_after_wait;
    @(posedge core_clk) disable iff (!arst_n)
      (state_q == RIVM_IDLE && any_w) |=> !irq_ack_q ##1 !irq_ack_q;
  endproperty
  a_ack_after_wait: assert property (p_ack_after_wait) else $error("ack too early");

  property p_single_reset;
    @(posedge core_clk) disable iff (!arst_n)
      (pc_load_q && !irq_ack_q) |-> $past(state_q) == RIVM_RESET;
  endproperty
  a_single_reset: assert property (p_single_reset) else $error("stray load");

endmodule

// ===== verilog/rivm_pkg.sv
package rivm_pkg;

  // Program counter width; 16K bytes of flash hold 8K words.
  localparam int unsigned PC_W = 13;

  // Number of vector slots after reset, including the unassigned ones.
  localparam int unsigned NUM_VEC = 31;

  // Reset address with the boot reset fuse unprogrammed.
  localparam logic [PC_W-1:0] RESET_ADDR_APP = 13'h0000;

  // Default boot loader start address; a plain default, it comes from the boot size setting.
  localparam logic [PC_W-1:0] BOOT_ADDR_DEFAULT = 13'h0c00;

  // Fuse encoding: one means unprogrammed.
  localparam logic FUSE_UNPROGRAMMED = 1'b1;

  // Vector slot index of each source; address is two words per slot after reset.
  localparam int unsigned VEC_STG2_CAPT  = 0;   // 0x0002
  localparam int unsigned VEC_STG2_END   = 1;   // 0x0004
  localparam int unsigned VEC_STG1_CAPT  = 2;   // 0x0006
  localparam int unsigned VEC_STG1_END   = 3;   // 0x0008
  localparam int unsigned VEC_STG0_CAPT  = 4;   // 0x000a
  localparam int unsigned VEC_STG0_END   = 5;   // 0x000c
  localparam int unsigned VEC_CMP0       = 6;   // 0x000e
  localparam int unsigned VEC_CMP1       = 7;   // 0x0010
  localparam int unsigned VEC_CMP2       = 8;   // 0x0012
  localparam int unsigned VEC_EXT0       = 9;   // 0x0014
  localparam int unsigned VEC_WT_CAPT    = 10;  // 0x0016
  localparam int unsigned VEC_WT_MA      = 11;  // 0x0018
  localparam int unsigned VEC_WT_MB      = 12;  // 0x001a
  localparam int unsigned VEC_SPARE0     = 13;  // 0x001c
  localparam int unsigned VEC_WT_OVF     = 14;  // 0x001e
  localparam int unsigned VEC_BT_MA      = 15;  // 0x0020
  localparam int unsigned VEC_BT_OVF     = 16;  // 0x0022
  localparam int unsigned VEC_ADC        = 17;  // 0x0024
  localparam int unsigned VEC_EXT1       = 18;  // 0x0026
  localparam int unsigned VEC_SPI        = 19;  // 0x0028
  localparam int unsigned VEC_SER_RX     = 20;  // 0x002a
  localparam int unsigned VEC_SER_EMPTY  = 21;  // 0x002c
  localparam int unsigned VEC_SER_TX     = 22;  // 0x002e
  localparam int unsigned VEC_EXT2       = 23;  // 0x0030
  localparam int unsigned VEC_WDOG       = 24;  // 0x0032
  localparam int unsigned VEC_EE         = 25;  // 0x0034
  localparam int unsigned VEC_BT_MB      = 26;  // 0x0036
  localparam int unsigned VEC_EXT3       = 27;  // 0x0038
  localparam int unsigned VEC_SPARE1     = 28;  // 0x003a
  localparam int unsigned VEC_SPARE2     = 29;  // 0x003c
  localparam int unsigned VEC_SPM        = 30;  // 0x003e

  // Slots with no source; their request lines are forced low.
  localparam logic [NUM_VEC-1:0] SPARE_MASK = 31'h3000_2000;

  // Table offset of the first interrupt vector and the step between vectors.
  localparam logic [PC_W-1:0] VEC_BASE_OFS = 13'h0001;
  localparam int unsigned     VEC_STEP     = 2;

  // Controller state.
  typedef enum logic [1:0] {
    RIVM_RESET,
    RIVM_IDLE,
    RIVM_WAIT_ACK
  } rivm_state_t;

endpackage

// ===== verilog/rivm_vec_rom.sv
// Vector address table: slot index to table offset, registered read data.
module rivm_vec_rom
  import rivm_pkg::*;
(
  input  wire logic                       core_clk,
  input  wire logic                       arst_n,
  input  wire logic [4:0]                 slot,
  output logic      [PC_W-1:0]            offset_q
);

  logic [PC_W-1:0] table_w [NUM_VEC];

  // One entry per slot: the printed address is 0x0002 times the vector number.
  for (genvar g = 0; g < NUM_VEC; g++) begin : g_tab
    assign table_w[g] = PC_W'((g + 1) * VEC_STEP);
  end

  // Registered read keeps the timing off the priority path.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      offset_q <= '0;
    end else begin
      offset_q <= table_w[slot];
    end
  end

endmodule

// ===== tb/rivm_src_core_model.sv
// Far side of the map: the request sources and the core that takes the vector.
module rivm_src_core_model
  import rivm_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        arst_n,
  input  wire logic [30:0] raise_mask,
  input  wire logic [3:0]  ack_delay,
  input  wire logic        irq_ack_q,
  input  wire logic [4:0]  irq_slot_q,
  output logic      [30:0] req,
  output logic             core_ack
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [3:0] wait_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Sources hold a level until their slot is accepted, and drop it at once.
  // Spare slots have no source, so they never ask.
  // The core may keep the vector waiting for ack_delay cycles, to test a slow answer.
  // spares stay quiet.
  always @(negedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      req      <= '0;
      wait_q   <= '0;
      core_ack <= 1'b0;
    end else begin
      req      <= (req | raise_mask) & ~SPARE_MASK & ~(irq_ack_q ? (31'h1 << irq_slot_q) : 31'h0);
      wait_q   <= (irq_ack_q || req == '0) ? 4'h0 : wait_q + 4'h1;
      core_ack <= !irq_ack_q && req != '0 && wait_q >= ack_delay;
    end
  end
endmodule

// ===== tb/test_reset_interrupt_vector_map.sv
// Self-checking bench for the reset and interrupt vector map.
module test_reset_interrupt_vector_map;
  import rivm_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;

  logic        core_clk, arst_n, boot_reset_fuse, vector_table_select, global_enable;
  logic        core_ack, pc_load_q, irq_ack_q;
  logic [12:0] boot_addr, pc_addr_q;
  logic [4:0]  irq_slot_q;
  logic [30:0] r, raise_mask;
  logic [3:0]  ack_delay;
  int          miscompares, checks;

  rivm_ctrl rivm_ctrl_inst (
    .core_clk(core_clk), .arst_n(arst_n), .boot_reset_fuse(boot_reset_fuse),
    .vector_table_select(vector_table_select), .boot_addr(boot_addr),
    .global_enable(global_enable), .stage_ctrl2_capture_irq(r[0]),
    .stage_ctrl2_cycle_end_irq(r[1]), .stage_ctrl1_capture_irq(r[2]),
    .stage_ctrl1_cycle_end_irq(r[3]), .stage_ctrl0_capture_irq(r[4]),
    .stage_ctrl0_cycle_end_irq(r[5]), .comparator_zero_irq(r[6]),
    .comparator_one_irq(r[7]), .comparator_two_irq(r[8]), .ext_request_zero(r[9]),
    .wide_timer_capture_irq(r[10]), .wide_timer_match_a_irq(r[11]),
    .wide_timer_match_b_irq(r[12]), .wide_timer_overflow_irq(r[14]),
    .byte_timer_match_a_irq(r[15]), .byte_timer_overflow_irq(r[16]),
    .converter_done_irq(r[17]), .ext_request_one(r[18]), .spi_done_irq(r[19]),
    .serial_rx_done_irq(r[20]), .serial_tx_empty_irq(r[21]), .serial_tx_done_irq(r[22]),
    .ext_request_two(r[23]), .watchdog_timeout_irq(r[24]), .eeprom_ready_irq(r[25]),
    .byte_timer_match_b_irq(r[26]), .ext_request_three(r[27]),
    .self_program_ready_irq(r[30]), .core_ack(core_ack), .pc_load_q(pc_load_q),
    .pc_addr_q(pc_addr_q), .irq_ack_q(irq_ack_q), .irq_slot_q(irq_slot_q));

  rivm_src_core_model rivm_src_core_model_inst (
    .core_clk(core_clk), .arst_n(arst_n), .raise_mask(raise_mask), .ack_delay(ack_delay),
    .irq_ack_q(irq_ack_q), .irq_slot_q(irq_slot_q), .req(r), .core_ack(core_ack));

  ////////////////////////////////////////////////////////////////////////////////
  // Free-running clock at 50 ns.
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  // Vector address: two words per slot after reset, moved by the boot start when selected.
  function automatic logic [12:0] vec_addr(int s, logic s_sel, logic [12:0] b);
    return (s_sel ? b : 13'h0000) + 13'(2 * (s + 1));
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Comparisons, one per kind of result.
  task automatic chk_addr(string n, logic [12:0] e, logic [12:0] g);
    checks++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic chk_slot(string n, logic [4:0] e, logic [4:0] g);
    chk_addr(n, {8'h00, e}, {8'h00, g});
  endtask

  task automatic chk_flag(string n, logic e, logic g);
    chk_addr(n, {12'h000, e}, {12'h000, g});
  endtask

  task automatic conclude();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Waits for the load or the ack pulse; a hang ends the run rather than stalling it.
  task automatic wait_out(bit use_load, int bound);
    for (int n = 0; n < bound; n++) begin
      @(posedge core_clk);
      #1;
      if ((use_load ? pc_load_q : irq_ack_q) === 1'b1) return;
    end
    miscompares++;
    $display("unexpected wait expected pulse seen none");
    conclude();
  endtask

  task automatic do_reset(logic f, logic s, logic [12:0] b);
    @(negedge core_clk);
    raise_mask <= '0;
    boot_reset_fuse = f;
    vector_table_select = s;
    boot_addr = b;
    arst_n = 1'b0;
    repeat (3) @(negedge core_clk);
    chk_flag("load_in_reset", 1'b0, pc_load_q);
    arst_n = 1'b1;
    wait_out(1, 10);
    chk_addr("reset_addr", f ? 13'h0000 : b, pc_addr_q);
    chk_flag("reset_ack", 1'b0, irq_ack_q);
  endtask

  // Each pending slot must come out once, lowest slot first, at its own address.
  task automatic expect_seq(logic [30:0] m);
    for (int s = 0; s < 31; s++) begin
      if (m[s]) begin
        wait_out(0, 60);
        chk_slot("slot", 5'(s), irq_slot_q);
        chk_addr("vector", vec_addr(s, vector_table_select, boot_addr), pc_addr_q);
        chk_flag("load", 1'b1, pc_load_q);
      end
    end
  endtask

  task automatic service(logic [30:0] m);
    @(negedge core_clk);
    raise_mask <= m;
    @(negedge core_clk);
    raise_mask <= '0;
    expect_seq(m);
  endtask

  function automatic logic [12:0] rnd_boot();
    return {5'($urandom_range(1, 31)), 8'h00};
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial begin
    arst_n = 1'b0;
    boot_reset_fuse = 1'b1;
    vector_table_select = 1'b0;
    boot_addr = BOOT_ADDR_DEFAULT;
    global_enable = 1'b1;
    raise_mask = '0;
    ack_delay = 4'h0;
    miscompares = 0;
    checks = 0;
    void'($urandom(50188));
    // Every strap combination; the reset address follows the fuse alone.
    for (int i = 0; i < 4; i++) do_reset(i[1], i[0], rnd_boot());
    // Every source alone, in both table positions.
    for (int t = 0; t < 2; t++) begin
      do_reset(1'b1, t[0], rnd_boot());
      for (int s = 0; s < 31; s++) if (!SPARE_MASK[s]) service(31'h1 << s);
    end
    // Requests held back while disabled, then served in order with a slow core.
    @(negedge core_clk);
    global_enable = 1'b0;
    ack_delay = 4'h4;
    raise_mask <= 31'h4800_0201;
    @(negedge core_clk);
    raise_mask <= '0;
    repeat (20) @(negedge core_clk) chk_flag("masked_ack", 1'b0, irq_ack_q);
    global_enable = 1'b1;
    expect_seq(31'h4800_0201);
    // A reset in mid-request leaves nothing stale behind.
    @(negedge core_clk);
    raise_mask <= 31'h0000_0040;
    do_reset(1'b0, 1'b1, rnd_boot());
    service(31'h0004_0000);
    // Random bursts with random core latency and table position.
    repeat (25) begin
      @(negedge core_clk);
      ack_delay = 4'($urandom_range(0, 5));
      vector_table_select = 1'($urandom);
      service(31'($urandom) & ~SPARE_MASK);
    end
    conclude();
  end
endmodule
